// *** verif/fsp_engine_model.sv ***
// program/erase engine and non-volatile store beside the status block
// assumes pulses from the block on the same rising clock; store survives reset
`timescale 1ns/1ps
module fsp_engine_model #(
	parameter int OP_CYC = 40
) (
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	// engine control from the block
	input  wire logic        start_i,
	input  wire logic        suspend_i,
	input  wire logic        resume_i,
	input  wire logic        store_i,
	input  wire logic [15:0] image_i,
	// answers to the block
	output logic             done_o,
	output logic      [15:0] image_o
);
	logic [15:0] store_r = 16'h0200;
	logic        run_r;
	int          cnt_r;

	// store keeps its image across power cycles, unlike the engine
	always @(posedge sys_clk_i) begin
		if (store_i) begin
			store_r <= image_i;
		end
	end
	assign image_o = store_r;

	// engine counts while running; a suspend freezes the count
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_r  <= 1'b0;
			cnt_r  <= 0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i || resume_i) begin
				run_r <= 1'b1;
				if (start_i) begin
					cnt_r <= 0;
				end
			end else if (suspend_i) begin
				run_r <= 1'b0;
			end else if (run_r) begin
				cnt_r <= cnt_r + 1;
				if (cnt_r == OP_CYC - 1) begin
					run_r  <= 1'b0;
					done_o <= 1'b1;
				end
			end
		end
	end
endmodule

// *** verif/fsp_status_protect_tb.sv ***
// self-checking bench for the status and protection block
// assumes the engine model as far side and a 100 MHz clock
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
	$display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module fsp_status_protect_tb;
	logic        sys_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        cmd_valid_i = 1'b0;
	logic [7:0]  cmd_code_i = 8'h00;
	logic [23:0] cmd_addr_i = 24'h000000;
	logic [7:0]  cmd_data_lo_i = 8'h00;
	logic [7:0]  cmd_data_hi_i = 8'h00;
	logic        cmd_two_i = 1'b1;
	logic        cmd_aligned_i = 1'b1;
	logic        op_done_i;
	logic [15:0] nv_image_i;
	logic [7:0]  sr1_o;
	logic [7:0]  sr2_o;
	logic        cmd_done_o;
	logic        cmd_refused_o;
	logic        op_start_o;
	fsp_pkg::fsp_op_t op_kind_o;
	logic [23:0] op_addr_o;
	logic        op_suspend_o;
	logic        op_resume_o;
	logic        nv_store_o;
	logic [15:0] nv_image_o;
	logic [2:0]  sec_locked_o;
	int          errors = 0;
	int          n_checks = 0;

	typedef struct packed {
		logic [7:0]  lo;
		logic [7:0]  hi;
		logic [7:0]  op;
		logic [23:0] addr;
		logic        ok;
	} fsp_case_t;
	fsp_case_t   cases [12];

	fsp_status_protect dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_addr_i(cmd_addr_i),
		.cmd_data_lo_i(cmd_data_lo_i), .cmd_data_hi_i(cmd_data_hi_i),
		.cmd_two_i(cmd_two_i), .cmd_aligned_i(cmd_aligned_i), .op_done_i(op_done_i),
		.nv_image_i(nv_image_i), .sr1_o(sr1_o), .sr2_o(sr2_o), .cmd_done_o(cmd_done_o),
		.cmd_refused_o(cmd_refused_o), .op_start_o(op_start_o), .op_kind_o(op_kind_o),
		.op_addr_o(op_addr_o), .op_suspend_o(op_suspend_o), .op_resume_o(op_resume_o),
		.nv_store_o(nv_store_o), .nv_image_o(nv_image_o), .sec_locked_o(sec_locked_o));

	fsp_engine_model eng (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .start_i(op_start_o),
		.suspend_i(op_suspend_o), .resume_i(op_resume_o), .store_i(nv_store_o),
		.image_i(nv_image_o), .done_o(op_done_i), .image_o(nv_image_i));

	// clock
	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// verdict and end of run
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// power cycle: reset for three cycles, then the load edge
	task automatic pwr();
		@(posedge sys_clk_i);
		rst_n_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
	endtask

	// one decoded command; checks accepted versus refused
	task automatic cmd(input logic [7:0] c, input logic [23:0] a, input logic [7:0] lo,
			input logic [7:0] hi, input logic al, input logic exp);
		logic ok;
		int   i;
		ok = 1'bx;
		@(posedge sys_clk_i);
		cmd_valid_i   <= 1'b1;
		cmd_code_i    <= c;
		cmd_addr_i    <= a;
		cmd_data_lo_i <= lo;
		cmd_data_hi_i <= hi;
		cmd_aligned_i <= al;
		@(posedge sys_clk_i);
		cmd_valid_i <= 1'b0;
		for (i = 0; i < 3; i++) begin
			#1;
			if (cmd_done_o === 1'b1 || cmd_refused_o === 1'b1) begin
				ok = cmd_done_o;
				break;
			end
			@(posedge sys_clk_i);
		end
		`CHK(ok, exp)
		// no answer within the bound ends the run
		if (ok === 1'bx) begin
			summarize();
		end
	endtask

	// bounded wait for the busy flag to drop
	task automatic wait_idle();
		int i;
		for (i = 0; i < 3000 && sr1_o[0] !== 1'b0; i++) begin
			@(posedge sys_clk_i);
			#1;
		end
		if (sr1_o[0] !== 1'b0) begin
			errors++;
			$display("[ERR] %0t busy never cleared", $time);
			summarize();
		end
	endtask

	// latched status write that runs to completion
	task automatic srw(input logic [7:0] lo, input logic [7:0] hi, input logic exp);
		cmd(8'h06, 24'h0, 8'h00, 8'h00, 1'b1, 1'b1);
		cmd(8'h01, 24'h0, lo, hi, 1'b1, exp);
		wait_idle();
	endtask

	function automatic fsp_pkg::fsp_op_t kind_of(input logic [7:0] c);
		case (c)
			8'h20: return fsp_pkg::FSP_OP_ERASE_4K;
			8'h52: return fsp_pkg::FSP_OP_ERASE_32K;
			8'hD8: return fsp_pkg::FSP_OP_ERASE_64K;
			8'h60, 8'hC7: return fsp_pkg::FSP_OP_ERASE_CHIP;
			default: return fsp_pkg::FSP_OP_PROG;
		endcase
	endfunction

	// main sequence
	initial begin
		cases = '{
			'{8'h14, 8'h40, 8'h20, 24'h0FF000, 1'b0}, '{8'h14, 8'h40, 8'h20, 24'h100000, 1'b1},
			'{8'h14, 8'h40, 8'h60, 24'h000000, 1'b0}, '{8'h1C, 8'h40, 8'hC7, 24'h000000, 1'b1},
			'{8'h44, 8'h40, 8'h20, 24'h1FF000, 1'b1}, '{8'h44, 8'h40, 8'h20, 24'h1FE000, 1'b0},
			'{8'h00, 8'h00, 8'h60, 24'h000000, 1'b1}, '{8'h04, 8'h00, 8'h32, 24'h1F0000, 1'b0},
			'{8'h04, 8'h00, 8'h02, 24'h1EFFFF, 1'b1}, '{8'h04, 8'h00, 8'h52, 24'h1E8000, 1'b1},
			'{8'h44, 8'h00, 8'hD8, 24'h1F0000, 1'b0}, '{8'h44, 8'h00, 8'hD8, 24'h1E0000, 1'b1}};
		pwr();
		#1;
		`CHK(sr1_o, 8'h00)
		`CHK(sr2_o, 8'h02)
		cmd(8'h01, 24'h0, 8'h00, 8'h00, 1'b1, 1'b0);
		// protection decode for both tables and every program/erase code
		foreach (cases[k]) begin
			srw(cases[k].lo, cases[k].hi, 1'b1);
			`CHK(sr2_o, cases[k].hi | 8'h02)
			cmd(8'h06, 24'h0, 8'h00, 8'h00, 1'b1, 1'b1);
			cmd(cases[k].op, cases[k].addr, 8'h00, 8'h00, 1'b1, cases[k].ok);
			if (cases[k].ok) begin
				`CHK(op_kind_o, kind_of(cases[k].op))
				`CHK(op_addr_o, cases[k].addr)
				`CHK(sr1_o[0], 1'b1)
				wait_idle();
				`CHK(sr1_o[1], 1'b0)
			end
		end
		// unaligned end and write disable
		cmd(8'h06, 24'h0, 8'h00, 8'h00, 1'b0, 1'b0);
		`CHK(sr1_o[1], 1'b0)
		cmd(8'h06, 24'h0, 8'h00, 8'h00, 1'b1, 1'b1);
		cmd(8'h04, 24'h0, 8'h00, 8'h00, 1'b1, 1'b1);
		`CHK(sr1_o, 8'h44)
		// status write busy, then locks and fixed quad bit
		cmd(8'h06, 24'h0, 8'h00, 8'h00, 1'b1, 1'b1);
		cmd(8'h01, 24'h0, 8'h00, 8'h08, 1'b1, 1'b1);
		`CHK(sr1_o, 8'h03)
		cmd(8'h06, 24'h0, 8'h00, 8'h00, 1'b1, 1'b0);
		cmd(8'h01, 24'h0, 8'h00, 8'h00, 1'b1, 1'b0);
		wait_idle();
		`CHK(sr1_o, 8'h00)
		`CHK(sr2_o, 8'h0A)
		`CHK(sec_locked_o, 3'h1)
		`CHK(nv_image_o, 16'h0A00)
		srw(8'h00, 8'h00, 1'b1);
		`CHK(sr2_o, 8'h0A)
		// one data byte only: second status byte stays as it was
		@(posedge sys_clk_i);
		cmd_two_i <= 1'b0;
		srw(8'h00, 8'h40, 1'b1);
		`CHK(sr2_o, 8'h0A)
		@(posedge sys_clk_i);
		cmd_two_i <= 1'b1;
		// suspend and resume of erase, then suspend of program cleared by a power cycle
		cmd(8'h75, 24'h0, 8'h00, 8'h00, 1'b1, 1'b0);
		cmd(8'h06, 24'h0, 8'h00, 8'h00, 1'b1, 1'b1);
		cmd(8'h20, 24'h100000, 8'h00, 8'h00, 1'b1, 1'b1);
		cmd(8'h75, 24'h0, 8'h00, 8'h00, 1'b1, 1'b1);
		`CHK({sr2_o[7], sr2_o[2], sr1_o[0]}, 3'b100)
		cmd(8'h7A, 24'h0, 8'h00, 8'h00, 1'b1, 1'b1);
		`CHK({sr2_o[7], sr1_o[0]}, 2'b01)
		wait_idle();
		cmd(8'h06, 24'h0, 8'h00, 8'h00, 1'b1, 1'b1);
		cmd(8'h02, 24'h000100, 8'h00, 8'h00, 1'b1, 1'b1);
		cmd(8'h75, 24'h0, 8'h00, 8'h00, 1'b1, 1'b1);
		`CHK({sr2_o[7], sr2_o[2]}, 2'b01)
		pwr();
		#1;
		`CHK(sr2_o, 8'h0A)
		// lock-down until power cycle, then one-time lock
		srw(8'h00, 8'h09, 1'b1);
		`CHK(sr2_o[0], 1'b1)
		srw(8'h00, 8'h08, 1'b0);
		pwr();
		#1;
		`CHK(sr2_o[0], 1'b0)
		srw(8'h80, 8'h09, 1'b1);
		pwr();
		#1;
		`CHK({sr1_o[7], sr2_o[0]}, 2'b11)
		srw(8'h00, 8'h00, 1'b0);
		summarize();
	end
endmodule

// *** verilog/fsp_pkg.sv ***
// constants shared by the status and protection logic of the serial flash
// assumes a 100 MHz system clock and a 2 MB array addressed by 21 bits
package fsp_pkg;

	// command codes handled here
	localparam logic [7:0] OP_WREN    = 8'h06;
	localparam logic [7:0] OP_WRDI    = 8'h04;
	localparam logic [7:0] OP_SRW     = 8'h01;
	localparam logic [7:0] OP_PP      = 8'h02;
	localparam logic [7:0] OP_QPP     = 8'h32;
	localparam logic [7:0] OP_SE      = 8'h20;
	localparam logic [7:0] OP_BE32    = 8'h52;
	localparam logic [7:0] OP_BE64    = 8'hD8;
	localparam logic [7:0] OP_CE_A    = 8'h60;
	localparam logic [7:0] OP_CE_B    = 8'hC7;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_RESUME  = 8'h7A;

	// first status register bit positions
	localparam int SR1_GUARD_LO = 7;
	localparam int SR1_PSEL_HI  = 6;
	localparam int SR1_PSEL_LO  = 2;
	localparam int SR1_LATCH    = 1;
	localparam int SR1_BUSY     = 0;

	// second status register bit positions, counted within its byte
	localparam int SR2_ERASE_HELD = 7;
	localparam int SR2_INVERT     = 6;
	localparam int SR2_LOCK_HI    = 5;
	localparam int SR2_LOCK_LO    = 3;
	localparam int SR2_PROG_HELD  = 2;
	localparam int SR2_QUAD       = 1;
	localparam int SR2_GUARD_HI   = 0;

	// values after reset
	localparam logic [7:0]  SR1_RESET   = 8'h00;
	localparam logic [7:0]  SR2_RESET   = 8'h02;
	localparam logic [15:0] NV_RESET    = 16'h0200;

	// array geometry
	localparam int          ARRAY_AW   = 21;
	localparam logic [20:0] FRAC_UNIT  = 21'h010000;
	localparam logic [20:0] AREA_UNIT  = 21'h001000;
	localparam logic [20:0] SECT_MASK  = 21'h000FFF;
	localparam logic [20:0] BLK32_MASK = 21'h007FFF;
	localparam logic [20:0] BLK64_MASK = 21'h00FFFF;

	// status write busy time
	localparam int          CLK_NS        = 10;
	localparam int          STATUS_WR_NS  = 2000;
	localparam logic [15:0] STATUS_WR_CYC = 16'((STATUS_WR_NS + CLK_NS - 1) / CLK_NS);

	// operation handed to the program and erase engines
	typedef enum logic [2:0] {
		FSP_OP_PROG,
		FSP_OP_ERASE_4K,
		FSP_OP_ERASE_32K,
		FSP_OP_ERASE_64K,
		FSP_OP_ERASE_CHIP
	} fsp_op_t;

	// control states
	typedef enum logic [2:0] {
		ST_BOOT,
		ST_IDLE,
		ST_SRW,
		ST_PROG,
		ST_ERASE,
		ST_HELD_PROG,
		ST_HELD_ERASE
	} fsp_state_t;

endpackage

// *** verilog/fsp_status_protect.sv ***
// status registers, write latch, suspend flags and array protection decode
// assumes a command framer on the same clock that hands over one decoded
// command per pulse, and engines that report the end of program or erase
`timescale 1ns/1ps

// Operation
// - inverted table: fractions and all-protected codes
// - inverted table: only small top/bottom areas free
// - first status byte bit layout
// - second status byte bit layout
// - busy flag set during write operations
// - cleared latch refuses writes, program, erase
// - protect bits via status write; guard ranges
// - chip erase only with matching protect code
// - guard bits 00 allow latched status writes
// - guard 10 locks until power cycle
// - guard 11 locks status writes forever
// - quad bit reads one, never changes
// - security lock bits set once, never clear
// - invert bit selects protection table
// - suspend sets erase or program held flag
// - resume and power cycle clear held flags
// - plain table: fractions or 4 KB to 32 KB
// - framer shifts MSB first on rising edges
// - unaligned chip select end discards command
module fsp_status_protect (
	// clock and reset
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_n_i,
	// decoded command from the serial framer
	input  wire logic                 cmd_valid_i,
	input  wire logic [7:0]           cmd_code_i,
	input  wire logic [23:0]          cmd_addr_i,
	input  wire logic [7:0]           cmd_data_lo_i,
	input  wire logic [7:0]           cmd_data_hi_i,
	input  wire logic                 cmd_two_i,
	input  wire logic                 cmd_aligned_i,
	// engine and non-volatile store
	input  wire logic                 op_done_i,
	input  wire logic [15:0]          nv_image_i,
	// status bytes
	output logic      [7:0]           sr1_o,
	output logic      [7:0]           sr2_o,
	// command outcome
	output logic                      cmd_done_o,
	output logic                      cmd_refused_o,
	// engine control
	output logic                      op_start_o,
	output fsp_pkg::fsp_op_t          op_kind_o,
	output logic      [23:0]          op_addr_o,
	output logic                      op_suspend_o,
	output logic                      op_resume_o,
	// non-volatile store and security registers
	output logic                      nv_store_o,
	output logic      [15:0]          nv_image_o,
	output logic      [2:0]           sec_locked_o
);

	fsp_pkg::fsp_state_t state_r, state_nxt;
	logic [4:0]  psel_r, psel_nxt;
	logic        guard_lo_r, guard_lo_nxt;
	logic        guard_hi_r, guard_hi_nxt;
	logic        latch_r, latch_nxt;
	logic        invert_r, invert_nxt;
	logic [2:0]  lock_r, lock_nxt;
	logic [15:0] timer_r, timer_nxt;
	logic [7:0]  sr1_r, sr1_nxt;
	logic [7:0]  sr2_r, sr2_nxt;
	logic        done_r, done_nxt;
	logic        refused_r, refused_nxt;
	logic        start_r, start_nxt;
	fsp_pkg::fsp_op_t kind_r, kind_nxt;
	logic [23:0] op_addr_r, op_addr_nxt;
	logic        susp_r, susp_nxt;
	logic        resume_r, resume_nxt;
	logic        store_r, store_nxt;
	logic [15:0] image_r, image_nxt;

	// protection check of an inclusive address span against the decoded range
	function automatic logic prot_hit(input logic [4:0] psel, input logic inv,
			input logic [20:0] lo_a, input logic [20:0] hi_a);
		logic [2:0]  n;
		logic [20:0] size;
		logic [20:0] bound;
		logic        upper;
		logic        s_in;
		logic        e_in;
		n = psel[4] ? (psel[2] ? 3'h4 : {1'b0, psel[1:0]}) : psel[2:0];
		size = (psel[4] ? fsp_pkg::AREA_UNIT : fsp_pkg::FRAC_UNIT) << (n - 3'h1);
		upper = ~psel[3];
		bound = upper ? (21'h000000 - size) : size;
		s_in = upper ? (lo_a >= bound) : (lo_a < bound);
		e_in = upper ? (hi_a >= bound) : (hi_a < bound);
		if (psel[2:0] == 3'h0) begin
			s_in = 1'b0;
			e_in = 1'b0;
		end else if (psel[2] & psel[1]) begin
			s_in = 1'b1;
			e_in = 1'b1;
		end
		// inverted table protects all but the plain region
		if (inv) begin
			prot_hit = ~(s_in & e_in);
		end else begin
			prot_hit = upper ? e_in : s_in;
		end
	endfunction

	// span touched by the requested command and its protection verdict
	logic [20:0] span_mask;
	logic [20:0] span_lo;
	logic [20:0] span_hi;
	logic        span_hit;
	logic        chip_ok;
	logic        busy_now;

	always_comb begin
		unique case (cmd_code_i)
			fsp_pkg::OP_SE:   span_mask = fsp_pkg::SECT_MASK;
			fsp_pkg::OP_BE32: span_mask = fsp_pkg::BLK32_MASK;
			fsp_pkg::OP_BE64: span_mask = fsp_pkg::BLK64_MASK;
			default:          span_mask = 21'h000000;
		endcase
		span_lo = cmd_addr_i[20:0] & ~span_mask;
		span_hi = span_lo | span_mask;
		span_hit = prot_hit(psel_r, invert_r, span_lo, span_hi);
		chip_ok = ((psel_r[2:0] == 3'h0) & ~invert_r) | ((psel_r[2:0] == 3'h7) & invert_r);
		busy_now = (state_r == fsp_pkg::ST_SRW) | (state_r == fsp_pkg::ST_PROG)
			| (state_r == fsp_pkg::ST_ERASE);
	end

	// command handling and next state of every register
	always_comb begin
		logic known;
		logic held;
		logic busy_n;
		known = 1'b0;
		held = (state_r == fsp_pkg::ST_HELD_PROG) | (state_r == fsp_pkg::ST_HELD_ERASE);
		busy_n = 1'b0;
		state_nxt = state_r;
		psel_nxt = psel_r;
		guard_lo_nxt = guard_lo_r;
		guard_hi_nxt = guard_hi_r;
		latch_nxt = latch_r;
		invert_nxt = invert_r;
		lock_nxt = lock_r;
		timer_nxt = timer_r;
		done_nxt = 1'b0;
		refused_nxt = 1'b0;
		start_nxt = 1'b0;
		kind_nxt = kind_r;
		op_addr_nxt = op_addr_r;
		susp_nxt = 1'b0;
		resume_nxt = 1'b0;
		store_nxt = 1'b0;
		image_nxt = image_r;
		unique case (cmd_code_i)
			fsp_pkg::OP_WREN, fsp_pkg::OP_WRDI, fsp_pkg::OP_SRW, fsp_pkg::OP_PP,
			fsp_pkg::OP_QPP, fsp_pkg::OP_SE, fsp_pkg::OP_BE32, fsp_pkg::OP_BE64,
			fsp_pkg::OP_CE_A, fsp_pkg::OP_CE_B, fsp_pkg::OP_SUSPEND,
			fsp_pkg::OP_RESUME: known = 1'b1;
			default: known = 1'b0;
		endcase
		unique case (state_r)
			// load the stored image once after power-up
			fsp_pkg::ST_BOOT: begin
				psel_nxt = nv_image_i[fsp_pkg::SR1_PSEL_HI:fsp_pkg::SR1_PSEL_LO];
				invert_nxt = nv_image_i[8 + fsp_pkg::SR2_INVERT];
				lock_nxt = nv_image_i[8 + fsp_pkg::SR2_LOCK_HI:8 + fsp_pkg::SR2_LOCK_LO];
				guard_lo_nxt = nv_image_i[fsp_pkg::SR1_GUARD_LO];
				guard_hi_nxt = nv_image_i[8 + fsp_pkg::SR2_GUARD_HI];
				// power cycle releases the lock-down mode only
				if (nv_image_i[8 + fsp_pkg::SR2_GUARD_HI] & ~nv_image_i[fsp_pkg::SR1_GUARD_LO]) begin
					guard_hi_nxt = 1'b0;
				end
				image_nxt = nv_image_i;
				state_nxt = fsp_pkg::ST_IDLE;
			end
			// status write in progress
			fsp_pkg::ST_SRW: begin
				busy_n = 1'b1;
				timer_nxt = timer_r - 16'h0001;
				if (timer_r == 16'h0001) begin
					latch_nxt = 1'b0;
					store_nxt = 1'b1;
					busy_n = 1'b0;
					state_nxt = fsp_pkg::ST_IDLE;
				end
				if (cmd_valid_i & known) begin
					refused_nxt = 1'b1;
				end
			end
			// program or erase running in the engine
			fsp_pkg::ST_PROG, fsp_pkg::ST_ERASE: begin
				busy_n = 1'b1;
				if (op_done_i) begin
					latch_nxt = 1'b0;
					busy_n = 1'b0;
					state_nxt = fsp_pkg::ST_IDLE;
				end else if (cmd_valid_i & known) begin
					if ((cmd_code_i == fsp_pkg::OP_SUSPEND) & cmd_aligned_i) begin
						susp_nxt = 1'b1;
						done_nxt = 1'b1;
						busy_n = 1'b0;
						state_nxt = (state_r == fsp_pkg::ST_ERASE) ? fsp_pkg::ST_HELD_ERASE
							: fsp_pkg::ST_HELD_PROG;
					end else begin
						refused_nxt = 1'b1;
					end
				end
			end
			// idle or suspended: take a new command
			default: begin
				if (cmd_valid_i & known) begin
					refused_nxt = 1'b1;
					if (cmd_aligned_i) begin
						unique case (cmd_code_i)
							fsp_pkg::OP_WREN: begin
								latch_nxt = 1'b1;
								refused_nxt = 1'b0;
								done_nxt = 1'b1;
							end
							fsp_pkg::OP_WRDI: begin
								latch_nxt = 1'b0;
								refused_nxt = 1'b0;
								done_nxt = 1'b1;
							end
							fsp_pkg::OP_SRW: begin
								// only guard modes 00 and 01, with the latch set and no suspend held, may write
								if (latch_r & ~held & ~guard_hi_r) begin
									psel_nxt = cmd_data_lo_i[fsp_pkg::SR1_PSEL_HI:fsp_pkg::SR1_PSEL_LO];
									guard_lo_nxt = cmd_data_lo_i[fsp_pkg::SR1_GUARD_LO];
									if (cmd_two_i) begin
										invert_nxt = cmd_data_hi_i[fsp_pkg::SR2_INVERT];
										lock_nxt = lock_r
											| cmd_data_hi_i[fsp_pkg::SR2_LOCK_HI:fsp_pkg::SR2_LOCK_LO];
										guard_hi_nxt = cmd_data_hi_i[fsp_pkg::SR2_GUARD_HI];
									end
									timer_nxt = fsp_pkg::STATUS_WR_CYC;
									busy_n = 1'b1;
									refused_nxt = 1'b0;
									done_nxt = 1'b1;
									state_nxt = fsp_pkg::ST_SRW;
								end
							end
							fsp_pkg::OP_PP, fsp_pkg::OP_QPP, fsp_pkg::OP_SE,
							fsp_pkg::OP_BE32, fsp_pkg::OP_BE64: begin
								if (latch_r & ~held & ~span_hit) begin
									start_nxt = 1'b1;
									op_addr_nxt = cmd_addr_i;
									busy_n = 1'b1;
									refused_nxt = 1'b0;
									done_nxt = 1'b1;
									if ((cmd_code_i == fsp_pkg::OP_PP) | (cmd_code_i == fsp_pkg::OP_QPP)) begin
										kind_nxt = fsp_pkg::FSP_OP_PROG;
										state_nxt = fsp_pkg::ST_PROG;
									end else begin
										kind_nxt = (cmd_code_i == fsp_pkg::OP_SE) ? fsp_pkg::FSP_OP_ERASE_4K
											: (cmd_code_i == fsp_pkg::OP_BE32) ? fsp_pkg::FSP_OP_ERASE_32K
											: fsp_pkg::FSP_OP_ERASE_64K;
										state_nxt = fsp_pkg::ST_ERASE;
									end
								end
							end
							fsp_pkg::OP_CE_A, fsp_pkg::OP_CE_B: begin
								if (latch_r & ~held & chip_ok) begin
									start_nxt = 1'b1;
									op_addr_nxt = 24'h000000;
									kind_nxt = fsp_pkg::FSP_OP_ERASE_CHIP;
									busy_n = 1'b1;
									refused_nxt = 1'b0;
									done_nxt = 1'b1;
									state_nxt = fsp_pkg::ST_ERASE;
								end
							end
							fsp_pkg::OP_RESUME: begin
								refused_nxt = 1'b0;
								done_nxt = 1'b1;
								if (held) begin
									resume_nxt = 1'b1;
									busy_n = 1'b1;
									state_nxt = (state_r == fsp_pkg::ST_HELD_ERASE) ? fsp_pkg::ST_ERASE
										: fsp_pkg::ST_PROG;
								end
							end
							default: refused_nxt = 1'b1;
						endcase
					end
				end
			end
		endcase
		// register images follow the next values so outputs stay in step
		sr1_nxt = {guard_lo_nxt, psel_nxt, latch_nxt, busy_n};
		sr2_nxt = {state_nxt == fsp_pkg::ST_HELD_ERASE, invert_nxt, lock_nxt,
			state_nxt == fsp_pkg::ST_HELD_PROG, 1'b1, guard_hi_nxt};
		if (store_nxt) begin
			image_nxt = {1'b0, invert_r, lock_r, 1'b0, 1'b1, guard_hi_r,
				guard_lo_r, psel_r, 2'b00};
		end
	end

	// state and output registers
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= fsp_pkg::ST_BOOT;
			psel_r <= 5'h00;
			guard_lo_r <= 1'b0;
			guard_hi_r <= 1'b0;
			latch_r <= 1'b0;
			invert_r <= 1'b0;
			lock_r <= 3'h0;
			timer_r <= 16'h0000;
			sr1_r <= fsp_pkg::SR1_RESET;
			sr2_r <= fsp_pkg::SR2_RESET;
			done_r <= 1'b0;
			refused_r <= 1'b0;
			start_r <= 1'b0;
			kind_r <= fsp_pkg::FSP_OP_PROG;
			op_addr_r <= 24'h000000;
			susp_r <= 1'b0;
			resume_r <= 1'b0;
			store_r <= 1'b0;
			image_r <= fsp_pkg::NV_RESET;
		end else begin
			state_r <= state_nxt;
			psel_r <= psel_nxt;
			guard_lo_r <= guard_lo_nxt;
			guard_hi_r <= guard_hi_nxt;
			latch_r <= latch_nxt;
			invert_r <= invert_nxt;
			lock_r <= lock_nxt;
			timer_r <= timer_nxt;
			sr1_r <= sr1_nxt;
			sr2_r <= sr2_nxt;
			done_r <= done_nxt;
			refused_r <= refused_nxt;
			start_r <= start_nxt;
			kind_r <= kind_nxt;
			op_addr_r <= op_addr_nxt;
			susp_r <= susp_nxt;
			resume_r <= resume_nxt;
			store_r <= store_nxt;
			image_r <= image_nxt;
		end
	end

	// outputs straight from registers
	assign sr1_o = sr1_r;
	assign sr2_o = sr2_r;
	assign cmd_done_o = done_r;
	assign cmd_refused_o = refused_r;
	assign op_start_o = start_r;
	assign op_kind_o = kind_r;
	assign op_addr_o = op_addr_r;
	assign op_suspend_o = susp_r;
	assign op_resume_o = resume_r;
	assign nv_store_o = store_r;
	assign nv_image_o = image_r;
	assign sec_locked_o = lock_r;

	// checks on the status and protection behaviour
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	logic cmd_live;
	assign cmd_live = cmd_valid_i & cmd_aligned_i & (state_r != fsp_pkg::ST_BOOT);

	a_busy_tracks_op: assert property (
		(state_r != fsp_pkg::ST_BOOT) |-> (sr1_o[fsp_pkg::SR1_BUSY] == busy_now))
		else $error("busy flag differs from operation state");
	a_latch_gate: assert property (
		cmd_live & (cmd_code_i == fsp_pkg::OP_SRW) & ~sr1_o[fsp_pkg::SR1_LATCH]
		|=> cmd_refused_o & ~cmd_done_o)
		else $error("status write taken with latch clear");
	a_quad_fixed: assert property (
		(state_r != fsp_pkg::ST_BOOT) |-> sr2_o[fsp_pkg::SR2_QUAD])
		else $error("quad bit not one");
	a_lock_sticky: assert property (
		($past(sr2_o[5:3]) & ~sr2_o[5:3]) == 3'h0)
		else $error("security lock bit cleared");
	a_guard_forever: assert property (
		cmd_live & (cmd_code_i == fsp_pkg::OP_SRW) & sr2_o[0] & sr1_o[7]
		|=> cmd_refused_o ##1 $stable(sr1_o[7:2]))
		else $error("status write accepted in permanent mode");
	a_guard_lockdown: assert property (
		cmd_live & (cmd_code_i == fsp_pkg::OP_SRW) & sr2_o[0] & ~sr1_o[7]
		|=> cmd_refused_o)
		else $error("status write accepted in lock-down mode");
	a_chip_gate: assert property (
		cmd_live & ((cmd_code_i == fsp_pkg::OP_CE_A) | (cmd_code_i == fsp_pkg::OP_CE_B)) & ~chip_ok
		|=> cmd_refused_o & ~op_start_o)
		else $error("chip erase started with wrong protect code");
	a_range_guard: assert property (
		cmd_live & (cmd_code_i == fsp_pkg::OP_SE) & span_hit |=> ~op_start_o)
		else $error("erase started in protected range");
	a_erase_hold: assert property (
		cmd_live & (cmd_code_i == fsp_pkg::OP_SUSPEND) & (state_r == fsp_pkg::ST_ERASE) & ~op_done_i
		|=> sr2_o[fsp_pkg::SR2_ERASE_HELD] & op_suspend_o & ~sr1_o[fsp_pkg::SR1_BUSY])
		else $error("erase suspend not flagged");
	a_resume_clear: assert property (
		cmd_live & (cmd_code_i == fsp_pkg::OP_RESUME)
		|=> ~sr2_o[fsp_pkg::SR2_ERASE_HELD] & ~sr2_o[fsp_pkg::SR2_PROG_HELD])
		else $error("held flag survives resume");
	a_unaligned_drop: assert property (
		cmd_valid_i & ~cmd_aligned_i & (cmd_code_i == fsp_pkg::OP_WREN) & (state_r == fsp_pkg::ST_IDLE)
		|=> ~cmd_done_o & $stable(sr1_o[fsp_pkg::SR1_LATCH]))
		else $error("unaligned command executed");
	a_srw_latch_clear: assert property (
		$fell(sr1_o[fsp_pkg::SR1_BUSY]) & ($past(state_r) == fsp_pkg::ST_SRW)
		|-> ~sr1_o[fsp_pkg::SR1_LATCH])
		else $error("latch still set after status write");

endmodule
